//--- clk_scale_map.vh
// register map and constants for the peripheral clock scale and gating block
`ifndef CLK_SCALE_MAP_VH
`define CLK_SCALE_MAP_VH

// =====================================================================
// register byte offsets
`define OFS_OSC_CTRL 8'h00
`define OFS_CFG_CTRL 8'h10
`define OFS_DIS_BASE 8'h40
`define OFS_DIS_LAST 8'h9c
`define DIS_STRIDE_LSB 4
`define ALIAS_LSB 2

// =====================================================================
// alias operations, low address bits of a disable register word
`define OP_WRITE 2'h0
`define OP_CLR 2'h1
`define OP_SET 2'h2
`define OP_INV 2'h3

// =====================================================================
// fields
`define DIV_HI 20
`define DIV_LO 19
`define LOCK_BIT 12
`define DIV_RESET 2'h0
`define LOCK_RESET 1'b0
`define DIS_RESET 32'h0000_0000

// =====================================================================
// disable bit positions
`define B_ADC 0
`define B_CHARGE_TIMER 8
`define B_COMP_REF 12
`define B_COMP1 0
`define B_CAPTURE1 0
`define B_COMPARE1 16
`define B_TIMER1 0
`define B_UART1 0
`define B_SPI1 8
`define B_I2C1 16
`define B_USB 24
`define B_CALENDAR 0
`define B_REFCLK_OUT 1
`define B_PARALLEL_PORT 16

// implemented bits of each disable register
`define IMPL_1 32'h0000_1101
`define IMPL_2 32'h0000_0007
`define IMPL_3 32'h001f_001f
`define IMPL_4 32'h0000_001f
`define IMPL_5 32'h0103_0303
`define IMPL_6 32'h0001_0003

`define NUM_MODULES 31

`endif

//--- disable_bank.v
// bank of six module disable words with write, clear, set and invert
`default_nettype none
`include "clk_scale_map.vh"

module disable_bank #(
	parameter [191:0] IMPL_MASK = {`IMPL_6, `IMPL_5, `IMPL_4,
		`IMPL_3, `IMPL_2, `IMPL_1}
) (
	input wire clk,
	input wire resetn,
	input wire wr_en,
	input wire [1:0] wr_op,
	input wire [2:0] wr_idx,
	input wire [31:0] wr_data,
	input wire [31:0] wr_mask,
	output wire [191:0] words
);

	reg [31:0] word [0:5];
	integer i;

	// =================================================================
	// update, one word per cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 6; i = i + 1) begin
				word[i] <= `DIS_RESET;
			end
		end else if (wr_en && wr_idx < 3'd6) begin
			// absent modules keep their bit at zero
			case (wr_op)
			`OP_CLR: word[wr_idx] <= word[wr_idx] & ~(wr_data & wr_mask);
			`OP_SET: word[wr_idx] <= (word[wr_idx] | (wr_data & wr_mask))
				& IMPL_MASK[wr_idx*32 +: 32];
			`OP_INV: word[wr_idx] <= (word[wr_idx] ^ (wr_data & wr_mask))
				& IMPL_MASK[wr_idx*32 +: 32];
			default: word[wr_idx] <= ((word[wr_idx] & ~wr_mask)
				| (wr_data & wr_mask)) & IMPL_MASK[wr_idx*32 +: 32];
			endcase
		end
	end

	assign words = {word[5], word[4], word[3], word[2], word[1], word[0]};

endmodule // disable_bank

`default_nettype wire

//--- periph_clock_control.v
// peripheral clock divider, module clock gating and disable register lock
// Notes on behaviour
// - divisor field in oscillator control bits 20:19 picks divide by 1,2,4,8
// - divisor change hits every peripheral tick; system-clock users unaffected
// - register reads complete on the next peripheral clock edge
// - a set disable bit stops every clock enable of that module
// - disabled module ignores register writes; its reads are invalid
// - disable bit 1 disables, 0 enables; reset clears to enabled
// - register 1,2,3 disable bit positions as mapped
// - register 4,5,6 disable bit positions as mapped
// - disable bits of absent modules are not implemented
// - writes to locked disable registers ack normally, change nothing
// - lock bit 12 of configuration control blocks disable register writes
// - lock bit changes only after the unlock sequence
// - with one-way option, set lock cannot clear until reset
// - disable registers reset to zero, clear/set/invert aliases at 4,8,c
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`default_nettype none
`include "clk_scale_map.vh"

module periph_clock_control #(
	parameter [191:0] IMPL_MASK = {`IMPL_6, `IMPL_5, `IMPL_4,
		`IMPL_3, `IMPL_2, `IMPL_1}
) (
	input wire clk,
	input wire resetn,
	// wishbone classic slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// unlock sequence done, from the oscillator unlock logic
	input wire unlock_ok,
	// one-way lock configuration bit
	input wire lock_one_way,
	// peripheral clock enable pulse, one system clock wide
	output reg periph_clk_en,
	output reg [1:0] periph_clk_divisor,
	output reg disable_write_lock,
	// per-module gated clock enable and write block
	output reg [`NUM_MODULES-1:0] module_tick,
	output reg [`NUM_MODULES-1:0] module_off
);

	// =================================================================
	// helpers
	function [31:0] byte_mask;
		input [3:0] sel;
		begin
			byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		end
	endfunction

	function [2:0] div_limit;
		input [1:0] div;
		begin
			case (div)
			2'h0: div_limit = 3'h0;
			2'h1: div_limit = 3'h1;
			2'h2: div_limit = 3'h3;
			default: div_limit = 3'h7;
			endcase
		end
	endfunction

	// =================================================================
	// address decode
	wire req = cyc_i && stb_i && !ack_o;
	wire hit_osc = adr_i == `OFS_OSC_CTRL;
	wire hit_cfg = adr_i == `OFS_CFG_CTRL;
	wire hit_dis = adr_i >= `OFS_DIS_BASE && adr_i <= `OFS_DIS_LAST;
	wire [7:0] dis_rel = adr_i - `OFS_DIS_BASE;
	wire [2:0] dis_idx = dis_rel[`DIS_STRIDE_LSB+2:`DIS_STRIDE_LSB];
	wire [1:0] dis_op = dis_rel[`ALIAS_LSB+1:`ALIAS_LSB];
	wire [31:0] wmask = byte_mask(sel_i);

	// =================================================================
	// divider; divisor change waits for a tick boundary
	reg [1:0] pending_div;
	reg [2:0] div_count;
	wire tick_now = div_count == div_limit(periph_clk_divisor);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending_div <= `DIV_RESET;
			periph_clk_divisor <= `DIV_RESET;
			div_count <= 3'h0;
			periph_clk_en <= 1'b0;
		end else begin
			if (req && we_i && hit_osc && sel_i[2]) begin
				pending_div <= dat_i[`DIV_HI:`DIV_LO];
			end
			periph_clk_en <= tick_now;
			if (tick_now) begin
				div_count <= 3'h0;
				// switch only here so no pulse is cut short
				periph_clk_divisor <= pending_div;
			end else begin
				div_count <= div_count + 3'h1;
			end
		end
	end

	// =================================================================
	// lock bit
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			disable_write_lock <= `LOCK_RESET;
		end else if (req && we_i && hit_cfg && sel_i[1] && unlock_ok) begin
			if (dat_i[`LOCK_BIT]) begin
				disable_write_lock <= 1'b1;
			end else if (!lock_one_way) begin
				disable_write_lock <= 1'b0;
			end
		end
	end

	// =================================================================
	// disable register bank
	wire [191:0] dis_words;
	// locked writes still ack but change nothing
	wire dis_wr = req && we_i && hit_dis && !disable_write_lock;

	disable_bank #(
		.IMPL_MASK(IMPL_MASK)
	) bank (
		.clk(clk),
		.resetn(resetn),
		.wr_en(dis_wr),
		.wr_op(dis_op),
		.wr_idx(dis_idx),
		.wr_data(dat_i),
		.wr_mask(wmask),
		.words(dis_words)
	);

	wire [31:0] d1 = dis_words[31:0];
	wire [31:0] d2 = dis_words[63:32];
	wire [31:0] d3 = dis_words[95:64];
	wire [31:0] d4 = dis_words[127:96];
	wire [31:0] d5 = dis_words[159:128];
	wire [31:0] d6 = dis_words[191:160];

	// module order: adc, charge_timer, comp_ref, comparator1..3,
	// capture1..5, compare1..5, timer1..5, uart1..2, spi1..2, i2c1..2,
	// usb, calendar, refclk_out, parallel_port
	wire [`NUM_MODULES-1:0] next_off = {
		d6[`B_PARALLEL_PORT], d6[`B_REFCLK_OUT], d6[`B_CALENDAR],
		d5[`B_USB], d5[`B_I2C1+1:`B_I2C1], d5[`B_SPI1+1:`B_SPI1],
		d5[`B_UART1+1:`B_UART1],
		d4[`B_TIMER1+4:`B_TIMER1],
		d3[`B_COMPARE1+4:`B_COMPARE1], d3[`B_CAPTURE1+4:`B_CAPTURE1],
		d2[`B_COMP1+2:`B_COMP1],
		d1[`B_COMP_REF], d1[`B_CHARGE_TIMER], d1[`B_ADC]
	};

	// usb runs from system clock, so its enable is always on when enabled
	localparam [`NUM_MODULES-1:0] SYS_CLOCKED = 31'h0800_0000;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			module_off <= {`NUM_MODULES{1'b0}};
			module_tick <= {`NUM_MODULES{1'b0}};
		end else begin
			// off modules also refuse their own register writes
			module_off <= next_off;
			// a set bit stops every enable of the module
			module_tick <= ~next_off
				& (SYS_CLOCKED | {`NUM_MODULES{tick_now}});
		end
	end

	// =================================================================
	// bus answer: writes ack next cycle, reads wait for a tick
	wire do_ack = req && (we_i || tick_now);
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h0000_0000;
		if (hit_osc) begin
			next_rdata[`DIV_HI:`DIV_LO] = periph_clk_divisor;
		end else if (hit_cfg) begin
			next_rdata[`LOCK_BIT] = disable_write_lock;
		end else if (hit_dis && dis_op == `OP_WRITE && dis_idx < 3'd6) begin
			next_rdata = dis_words[dis_idx*32 +: 32];
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= do_ack;
			if (do_ack && !we_i) begin
				dat_o <= next_rdata;
			end
		end
	end

endmodule // periph_clock_control

`default_nettype wire

//--- periph_clock_control_asserts.sv
// assertions for the peripheral clock scale and gating block
`default_nettype none
module periph_clock_control_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic ack_o,
	input wire logic lock_one_way,
	input wire logic periph_clk_en,
	input wire logic [1:0] periph_clk_divisor,
	input wire logic disable_write_lock,
	input wire logic [30:0] module_tick,
	input wire logic [30:0] module_off
);
	// ========
	// bus and clock relations
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire req = cyc_i && stb_i && !ack_o;
	property p_wr_ack;
		req && we_i |=> ack_o;
	endproperty
	a_wr_ack: assert property (p_wr_ack)
		else $error("write not acked");
	property p_rd_ack;
		req && !we_i |-> ##[1:8] ack_o;
	endproperty
	a_rd_ack: assert property (p_rd_ack)
		else $error("read too slow");
	property p_rd_edge;
		ack_o && !we_i |-> periph_clk_en;
	endproperty
	a_rd_edge: assert property (p_rd_edge)
		else $error("read off edge");
	property p_gate;
		(module_tick & module_off) == 31'h0;
	endproperty
	a_gate: assert property (p_gate)
		else $error("off module ticks");
	property p_div8;
		periph_clk_en && periph_clk_divisor == 2'h3 |=>
			!periph_clk_en [*7] ##1 periph_clk_en;
	endproperty
	a_div8: assert property (p_div8)
		else $error("bad 1:8 period");
	property p_div_edge;
		$changed(periph_clk_divisor) |-> periph_clk_en;
	endproperty
	a_div_edge: assert property (p_div_edge)
		else $error("divisor mid period");
	property p_one_way;
		disable_write_lock && lock_one_way |=> disable_write_lock;
	endproperty
	a_one_way: assert property (p_one_way)
		else $error("lock cleared");
	// usb runs from the system clock, so it ticks every cycle while enabled
	property p_usb;
		$past(resetn) && !module_off[27] |-> module_tick[27];
	endproperty
	a_usb: assert property (p_usb)
		else $error("usb tick missing");
	c_slow_read: cover property (ack_o && !we_i && periph_clk_divisor == 2'h3);
	c_lock: cover property (disable_write_lock && lock_one_way);
	c_usb_off: cover property (module_off[27]);
endmodule // periph_clock_control_asserts
bind periph_clock_control periph_clock_control_asserts
	periph_clock_control_asserts_inst (
	.clk, .resetn, .cyc_i, .stb_i, .we_i, .ack_o, .lock_one_way,
	.periph_clk_en, .periph_clk_divisor, .disable_write_lock,
	.module_tick, .module_off);
`default_nettype wire

//--- periph_clock_control_tb.sv
// self-checking bench for the peripheral clock scale and gating block
`default_nettype none
`include "clk_scale_map.vh"
module periph_clock_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, cyc_i, stb_i, we_i, unlock_ok, lock_one_way, ack_o;
	logic periph_clk_en, disable_write_lock;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q, seed;
	logic [1:0] periph_clk_divisor;
	logic [30:0] module_tick, module_off;
	logic [31:0] impl [6];
	logic [31:0] mdl [6];
	int fails, checked, n;
	periph_clock_control periph_clock_control_inst (.clk, .resetn, .cyc_i,
		.stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .unlock_ok,
		.lock_one_way, .periph_clk_en, .periph_clk_divisor,
		.disable_write_lock, .module_tick, .module_off);
	// ========
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// implemented bits, scanned word by word, give the module order
	function automatic logic [31:0] offv();
		int k;
		k = 0;
		offv = '0;
		for (int i = 0; i < 6; i++)
			for (int b = 0; b < 32; b++)
				if (impl[i][b]) begin
					offv[k] = mdl[i][b];
					k++;
				end
	endfunction
	task automatic close_out();
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic dis(input int i, input int op, input logic [31:0] d,
		input logic lk);
		bus(1'b1, 8'(8'h40 + i * 16 + op * 4), d);
		if (!lk)
			case (op)
			0: mdl[i] = d & impl[i];
			1: mdl[i] = mdl[i] & ~d;
			2: mdl[i] = mdl[i] | (d & impl[i]);
			default: mdl[i] = mdl[i] ^ (d & impl[i]);
			endcase
		repeat (3) @(posedge clk);
		chk({1'b0, module_off}, offv());
		chk({1'b0, module_tick & module_off}, 32'h0);
		bus(1'b0, 8'(8'h40 + i * 16), 32'h0);
		chk(q, mdl[i]);
	endtask
	task automatic lk(input logic d, input logic e);
		bus(1'b1, 8'h10, {19'h0, d, 12'h0});
		@(posedge clk);
		chk({31'h0, disable_write_lock}, {31'h0, e});
	endtask
	// ========
	// clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		fails++;
		close_out();
	end
	initial begin
		resetn = 1'b0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'hf;
		dat_i = 32'h0;
		unlock_ok = 1'b1;
		lock_one_way = 1'b0;
		impl = '{`IMPL_1, `IMPL_2, `IMPL_3, `IMPL_4, `IMPL_5, `IMPL_6};
		mdl = '{default: 32'h0};
		seed = 32'h660c;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			dis(i, 1, 32'h0, 1'b0);
			dis(i, 0, 32'hffff_ffff, 1'b0);
			for (int op = 0; op < 4; op++) begin
				seed = lfsr(seed);
				dis(i, op, seed, 1'b0);
			end
		end
		lk(1'b1, 1'b1);
		dis(0, 3, 32'hffff_ffff, 1'b1);
		unlock_ok <= 1'b0;
		lk(1'b0, 1'b1);
		unlock_ok <= 1'b1;
		lock_one_way <= 1'b1;
		lk(1'b0, 1'b1);
		lock_one_way <= 1'b0;
		lk(1'b0, 1'b0);
		// bench software has no enable bits and no busy usb to wait on
		dis(4, 2, 32'h0100_0000, 1'b0);
		bus(1'b0, 8'hf0, 32'h0);
		chk(q, 32'h0);
		for (int d = 3; d >= 0; d--) begin
			bus(1'b1, 8'h00, {11'h0, d[1:0], 19'h0});
			repeat (20) @(posedge clk);
			chk({30'h0, periph_clk_divisor}, 32'(d));
			do @(posedge clk); while (!periph_clk_en);
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!periph_clk_en);
			chk(32'(n), 32'(1 << d));
			chk({1'b0, module_tick}, {1'b0, ~module_off});
			bus(1'b0, 8'h00, 32'h0);
			chk(q & 32'h0018_0000, {11'h0, d[1:0], 19'h0});
		end
		lock_one_way <= 1'b1;
		lk(1'b1, 1'b1);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		lock_one_way <= 1'b0;
		mdl = '{default: 32'h0};
		lk(1'b0, 1'b0);
		for (int i = 0; i < 6; i++)
			dis(i, 1, 32'h0, 1'b0);
		close_out();
	end
endmodule // periph_clock_control_tb
`default_nettype wire
